/* bench/lcas_tb.sv */
// Self-checking bench for the twelve-channel alarm status block
`timescale 1ns/1ps

module testbench;
  import lcas_pkg::*;

  logic                   clk;
  logic                   reset_n;
  logic                   ce;
  logic                   cyc;
  logic                   stb;
  logic                   we;
  logic [LCAS_ADR_W-1:0]  adr;
  logic [3:0]             sel;
  logic [LCAS_DATA_W-1:0] dat_i;
  logic [LCAS_DATA_W-1:0] dat_o;
  logic                   ack;
  logic                   irq;
  logic [11:0]            prbs;
  logic [11:0]            dlos;
  logic [11:0]            alos;
  logic [11:0]            fifo;
  logic [11:0]            unlock;
  logic [11:0]            sabs;
  logic [11:0]            drvmon;
  logic [31:0]            rd;
  int                     err_count;
  int                     cmp_count;

  lcas_top #(.NCH(12)) dut (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .PRBS_SYNC_LOST(prbs), .DIGITAL_SIGNAL_ABSENT(dlos), .ANALOG_SIGNAL_ABSENT(alos),
    .FIFO_LIMIT_ALARM(fifo), .CLOCK_RECOVERY_UNLOCKED(unlock), .SIGNAL_ABSENT(sabs),
    .DRIVE_MONITOR_OUTPUT(drvmon), .CHANGE_IRQ(irq)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Codes 6 and 7 are holes in the channel numbering
  function automatic logic [9:0] reg_adr(input int c, input logic [3:0] r);
    logic [3:0] m;
    m = (c < 6) ? 4'(c) : 4'(c + 2);
    return {m, r, 2'b00};
  endfunction

  // Entered just after an edge; leaves one idle cycle so calls can run back to back
  task automatic wb_xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_i <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk_word(q, exp, what);
  endtask

  task automatic set_alarm(input int c, input logic [6:0] p);
    prbs[c] <= p[6];
    dlos[c] <= p[5];
    alos[c] <= p[4];
    fifo[c] <= p[3];
    unlock[c] <= p[2];
    sabs[c] <= p[1];
    drvmon[c] <= p[0];
    repeat (2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    err_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    ce = 1'b1;
    {cyc, stb, we, sel, adr, dat_i} = '0;
    {prbs, dlos, alos, fifo, unlock, sabs, drvmon} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0, "irq after reset");
    for (int c = 0; c < 12; c++) begin
      rd_chk(reg_adr(c, LCAS_REG_FLAGS), 32'h0, "flags after reset");
      rd_chk(reg_adr(c, LCAS_REG_ENABLE), 32'h0, "enable after reset");
      set_alarm(c, 7'h02);
      rd_chk(reg_adr(c, LCAS_REG_FLAGS), 32'h2, "absent change flag");
      rd_chk(reg_adr(c, LCAS_REG_ALARM), 32'h2, "live absent");
      rd_chk(reg_adr(c, LCAS_REG_FLAGS), 32'h0, "flags cleared by read");
      set_alarm(c, 7'h01);
      rd_chk(reg_adr(c, LCAS_REG_FLAGS), 32'h3, "both changes");
      rd_chk(reg_adr(c, LCAS_REG_ALARM), 32'h1, "live drive monitor");
      set_alarm(c, 7'h00);
      rd_chk(reg_adr(c, LCAS_REG_FLAGS), 32'h1, "drive monitor fall");
    end
    // Walking one over every alarm bit, then a write that must not stick
    for (int b = 0; b < 7; b++) begin
      set_alarm(7, 7'(1 << b));
      rd_chk(reg_adr(7, LCAS_REG_ALARM), 32'(1 << b), "alarm bit");
    end
    set_alarm(7, 7'h7f);
    wb_xfer(1'b1, reg_adr(7, LCAS_REG_ALARM), 32'h0, rd);
    rd_chk(reg_adr(7, LCAS_REG_ALARM), 32'h7f, "alarm read-only, bit 7 zero");
    set_alarm(7, 7'h00);
    wb_xfer(1'b0, reg_adr(7, LCAS_REG_FLAGS), 32'h0, rd);
    rd_chk({4'h6, LCAS_REG_FLAGS, 2'b00}, 32'h0, "unmapped code 6");
    rd_chk({4'he, LCAS_REG_ALARM, 2'b00}, 32'h0, "unmapped code e");
    // Enabled drive-monitor change raises the interrupt on both edges
    wb_xfer(1'b1, reg_adr(11, LCAS_REG_ENABLE), 32'h1, rd);
    rd_chk(reg_adr(11, LCAS_REG_ENABLE), 32'h1, "enable readback");
    for (int v = 1; v >= 0; v--) begin
      drvmon[11] <= 1'(v);
      repeat (3) @(posedge clk);
      chk_bit(irq, 1'b1, "irq on toggle");
      rd_chk(reg_adr(11, LCAS_REG_FLAGS), 32'h1, "toggle flag");
      chk_bit(irq, 1'b0, "irq after clear");
    end
    set_alarm(11, 7'h02);
    chk_bit(irq, 1'b0, "absent change not enabled");
    wb_xfer(1'b1, reg_adr(11, LCAS_REG_ENABLE), 32'h2, rd);
    @(posedge clk);
    chk_bit(irq, 1'b1, "absent change enabled");
    wb_xfer(1'b0, reg_adr(11, LCAS_REG_FLAGS), 32'h0, rd);
    // Change landing on the clearing edge must survive the read
    sabs[0] <= 1'b1;
    rd_chk(reg_adr(0, LCAS_REG_FLAGS), 32'h0, "flags before clear");
    rd_chk(reg_adr(0, LCAS_REG_FLAGS), 32'h2, "change kept past clear");
    // Frozen enable: a change made meanwhile is seen at the first enabled edge
    ce <= 1'b0;
    sabs[5] <= 1'b1;
    repeat (3) @(posedge clk);
    chk_bit(irq, 1'b0, "irq frozen low");
    ce <= 1'b1;
    @(posedge clk);
    rd_chk(reg_adr(5, LCAS_REG_FLAGS), 32'h2, "change seen after freeze");
    rd_chk(reg_adr(5, LCAS_REG_ALARM), 32'h2, "live absent after freeze");
    complete_run();
  end
endmodule

/* rtl/lcas_chan.sv */
// One channel: change detection and clear-on-read change flags
`timescale 1ns/1ps

module lcas_chan
  import lcas_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   signal_absent,
  input  wire logic                   drive_monitor_output,
  input  wire logic                   clear_on_read,
  output logic      [LCAS_FLAG_W-1:0] flags
);

  // ==========================================================================
  // Change detection
  // ==========================================================================
  logic                   armed_q;
  logic                   armed_d;
  logic [LCAS_FLAG_W-1:0] prev_q;
  logic [LCAS_FLAG_W-1:0] prev_d;
  logic [LCAS_FLAG_W-1:0] flag_q;
  logic [LCAS_FLAG_W-1:0] flag_d;
  logic [LCAS_FLAG_W-1:0] live;
  logic [LCAS_FLAG_W-1:0] change;

  assign live = {signal_absent, drive_monitor_output};

  always_comb begin
    armed_d = armed_q;
    prev_d  = prev_q;
    flag_d  = flag_q;
    change  = '0;
    if (ce) begin
      // First cycle only loads history, so a level present at reset is no change
      armed_d = 1'b1;
      prev_d  = live;
      if (armed_q) begin
        change = live ^ prev_q;
      end
      // Set wins over the clear so an event in the read cycle survives
      flag_d = (flag_q & ~{LCAS_FLAG_W{clear_on_read}}) | change;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      prev_q  <= '0;
      flag_q  <= LCAS_FLAGS_RST;
    end else begin
      armed_q <= armed_d;
      prev_q  <= prev_d;
      flag_q  <= flag_d;
    end
  end

  assign flags = flag_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_absent_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && armed_q && (signal_absent != prev_q[LCAS_BIT_ABSENT]) |=> flag_q[LCAS_BIT_ABSENT])
    else $error("signal absent change not latched");

  a_drive_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    ce && armed_q && (drive_monitor_output != prev_q[LCAS_BIT_DRIVE]) |=> flag_q[LCAS_BIT_DRIVE])
    else $error("drive monitor change not latched");

  a_flag_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && clear_on_read && armed_q && (live == prev_q) |=> flag_q == '0)
    else $error("change flags not cleared by read");

  a_event_kept_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && clear_on_read && armed_q && (live != prev_q) |=> (flag_q & $past(live ^ prev_q)) != '0)
    else $error("event lost during clearing read");

  a_flag_stays_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !ce || (flag_q == '0 && live == prev_q) |=> flag_q == '0 || $past(flag_q) != '0)
    else $error("flag set without a change");

  c_both_edges_drive: cover property (@(posedge clk) disable iff (!rst_n)
    ce && armed_q && drive_monitor_output && !prev_q[LCAS_BIT_DRIVE] ##[1:50]
    ce && !drive_monitor_output && prev_q[LCAS_BIT_DRIVE]);

endmodule

/* rtl/lcas_pkg.sv */
// Constants shared by the line channel alarm status block
package lcas_pkg;

  // ==========================================================================
  // Geometry
  // ==========================================================================
  localparam int         LCAS_NUM_CH    = 12;
  localparam int         LCAS_DATA_W    = 32;
  localparam int         LCAS_ADR_W     = 10;
  localparam int         LCAS_IDX_LSB   = 2;
  localparam int         LCAS_REG_W     = 8;
  localparam int         LCAS_ALARM_W   = 7;
  localparam int         LCAS_FLAG_W    = 2;

  // ==========================================================================
  // Register index: upper nibble is the channel code, lower nibble the register
  // ==========================================================================
  localparam logic [3:0] LCAS_REG_ENABLE = 4'h1;
  localparam logic [3:0] LCAS_REG_FLAGS  = 4'h2;
  localparam logic [3:0] LCAS_REG_ALARM  = 4'h3;

  // Channel codes 0-5 map to channels 0-5, codes 8-d to channels 6-11
  localparam logic [3:0] LCAS_LO_CHANS   = 4'h6;
  localparam logic [3:0] LCAS_M_HI_BASE  = 4'h8;
  localparam logic [3:0] LCAS_M_HI_LAST  = 4'hd;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         LCAS_BIT_DRIVE  = 0;
  localparam int         LCAS_BIT_ABSENT = 1;
  localparam logic [LCAS_FLAG_W-1:0] LCAS_FLAGS_RST  = 2'h0;
  localparam logic [LCAS_FLAG_W-1:0] LCAS_ENABLE_RST = 2'h0;

endpackage

/* rtl/lcas_top.sv */
// Twelve-channel alarm status and change flags behind a classic Wishbone slave
//
// Contract
// - Signal-absent change latches flag bit 1, clear-on-read
// - Drive-monitor change latches flag bit 0, clear-on-read
// - Live signal-absent readable at alarm state bit 1
// - Live drive-monitor readable at alarm state bit 0
// - Alarm state bits 6..0 read-only, bit 7 reserved
// - Per-channel flags at 0xm2, m 0-5, 8-d
// - Enabled drive-monitor toggle either way raises interrupt
`timescale 1ns/1ps

module lcas_top
  import lcas_pkg::*;
#(
  parameter int NCH = LCAS_NUM_CH
) (
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   CE,
  input  wire logic                   WB_CYC_I,
  input  wire logic                   WB_STB_I,
  input  wire logic                   WB_WE_I,
  input  wire logic [LCAS_ADR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]             WB_SEL_I,
  input  wire logic [LCAS_DATA_W-1:0] WB_DAT_I,
  output logic      [LCAS_DATA_W-1:0] WB_DAT_O,
  output logic                        WB_ACK_O,
  input  wire logic [NCH-1:0]         PRBS_SYNC_LOST,
  input  wire logic [NCH-1:0]         DIGITAL_SIGNAL_ABSENT,
  input  wire logic [NCH-1:0]         ANALOG_SIGNAL_ABSENT,
  input  wire logic [NCH-1:0]         FIFO_LIMIT_ALARM,
  input  wire logic [NCH-1:0]         CLOCK_RECOVERY_UNLOCKED,
  input  wire logic [NCH-1:0]         SIGNAL_ABSENT,
  input  wire logic [NCH-1:0]         DRIVE_MONITOR_OUTPUT,
  output logic                        CHANGE_IRQ
);

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Returns {valid, channel}; codes 6, 7, e and f hold no channel
  function automatic logic [4:0] chan_decode(input logic [3:0] m);
    logic [4:0] r;
    r = 5'h00;
    if (m < LCAS_LO_CHANS) begin
      r = {1'b1, m};
    end else if (m >= LCAS_M_HI_BASE && m <= LCAS_M_HI_LAST) begin
      r = {1'b1, 4'(m - LCAS_M_HI_BASE + LCAS_LO_CHANS)};
    end
    return r;
  endfunction

  logic [7:0] idx;
  logic [4:0] dec;
  logic       hit;
  logic [3:0] ch;
  logic [3:0] reg_sel;

  assign idx     = WB_ADR_I[LCAS_IDX_LSB +: 8];
  assign dec     = chan_decode(idx[7:4]);
  assign hit     = dec[4];
  assign ch      = dec[3:0];
  assign reg_sel = idx[3:0];

  // ==========================================================================
  // Channels
  // ==========================================================================
  logic [LCAS_FLAG_W-1:0]  flags     [NCH];
  logic [LCAS_FLAG_W-1:0]  enable_q  [NCH];
  logic [LCAS_FLAG_W-1:0]  enable_d  [NCH];
  logic [LCAS_ALARM_W-1:0] alarm_vec [NCH];
  logic [NCH-1:0]          clr;
  logic [NCH-1:0]          pend;
  logic                    req;
  logic                    ack_q;
  logic                    ack_d;
  logic [LCAS_DATA_W-1:0]  dat_q;
  logic [LCAS_DATA_W-1:0]  dat_d;
  logic                    irq_q;
  logic                    irq_d;

  assign req = WB_CYC_I && WB_STB_I && !ack_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // Live alarm word, bit 6 down to bit 0
      assign alarm_vec[g] = {PRBS_SYNC_LOST[g], DIGITAL_SIGNAL_ABSENT[g], ANALOG_SIGNAL_ABSENT[g],
                             FIFO_LIMIT_ALARM[g], CLOCK_RECOVERY_UNLOCKED[g], SIGNAL_ABSENT[g],
                             DRIVE_MONITOR_OUTPUT[g]};

      // Clear in the edge that captures the read data, so nothing falls between
      assign clr[g] = CE && req && !WB_WE_I && hit && (ch == 4'(g)) &&
                      (reg_sel == LCAS_REG_FLAGS);

      assign pend[g] = |(flags[g] & enable_q[g]);

      lcas_chan u_chan (
        .clk                  (CLK),
        .rst_n                (RESET_N),
        .ce                   (CE),
        .signal_absent        (SIGNAL_ABSENT[g]),
        .drive_monitor_output (DRIVE_MONITOR_OUTPUT[g]),
        .clear_on_read        (clr[g]),
        .flags                (flags[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  // Answer one cycle after the strobe; unmapped addresses still ack with zero
  always_comb begin
    ack_d = ack_q;
    dat_d = dat_q;
    irq_d = irq_q;
    for (int i = 0; i < NCH; i++) begin
      enable_d[i] = enable_q[i];
    end
    if (CE) begin
      ack_d = req;
      irq_d = |pend;
      if (req) begin
        dat_d = '0;
        if (!WB_WE_I && hit) begin
          unique case (reg_sel)
            LCAS_REG_ENABLE: dat_d[LCAS_FLAG_W-1:0]  = enable_q[ch];
            LCAS_REG_FLAGS:  dat_d[LCAS_FLAG_W-1:0]  = flags[ch];
            LCAS_REG_ALARM:  dat_d[LCAS_ALARM_W-1:0] = alarm_vec[ch];
            default:         dat_d = '0;
          endcase
        end
      end
      // Writes land at the edge where the master sees ack; read-only words ignore them
      if (ack_q && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && hit &&
          reg_sel == LCAS_REG_ENABLE) begin
        enable_d[ch] = WB_DAT_I[LCAS_FLAG_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_q <= 1'b0;
      dat_q <= '0;
      irq_q <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        enable_q[i] <= LCAS_ENABLE_RST;
      end
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_q <= irq_d;
      for (int i = 0; i < NCH; i++) begin
        enable_q[i] <= enable_d[i];
      end
    end
  end

  assign WB_ACK_O   = ack_q;
  assign WB_DAT_O   = dat_q;
  assign CHANGE_IRQ = irq_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic [LCAS_ALARM_W-1:0] sel_alarm;
  logic [LCAS_FLAG_W-1:0]  sel_flags;

  assign sel_alarm = hit ? alarm_vec[ch] : '0;
  assign sel_flags = hit ? flags[ch] : '0;

  // A frozen enable legally holds ack, so only enabled edges must drop it
  a_ack_single_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");

  a_ack_next_cycle: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not given one cycle after strobe");

  a_alarm_live_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req && !WB_WE_I && hit && reg_sel == LCAS_REG_ALARM
    |=> WB_ACK_O && WB_DAT_O[LCAS_ALARM_W-1:0] == $past(sel_alarm))
    else $error("alarm state read differs from live alarms");

  a_alarm_reserved_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O && $past(reg_sel) == LCAS_REG_ALARM |-> WB_DAT_O[LCAS_DATA_W-1:LCAS_ALARM_W] == '0)
    else $error("reserved alarm bits not zero");

  a_flags_read_value: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req && !WB_WE_I && hit && reg_sel == LCAS_REG_FLAGS
    |=> WB_DAT_O == {{(LCAS_DATA_W-LCAS_FLAG_W){1'b0}}, $past(sel_flags)})
    else $error("change flags read wrong");

  a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req && !hit |=> WB_ACK_O && WB_DAT_O == '0)
    else $error("unmapped channel code did not read zero");

  a_flags_clear_read: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && req && !WB_WE_I && hit && reg_sel == LCAS_REG_FLAGS && ch == 4'h0 &&
    SIGNAL_ABSENT[0] == $past(SIGNAL_ABSENT[0]) && DRIVE_MONITOR_OUTPUT[0] == $past(DRIVE_MONITOR_OUTPUT[0])
    ##1 CE && SIGNAL_ABSENT[0] == $past(SIGNAL_ABSENT[0]) &&
    DRIVE_MONITOR_OUTPUT[0] == $past(DRIVE_MONITOR_OUTPUT[0]) |-> flags[0] == '0)
    else $error("read did not clear change flags");

  // Watches the last channel, the one whose drive-monitor enable the tests set
  a_drive_toggle_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && g_ch[NCH-1].u_chan.armed_q && enable_q[NCH-1][LCAS_BIT_DRIVE] &&
    DRIVE_MONITOR_OUTPUT[NCH-1] != g_ch[NCH-1].u_chan.prev_q[LCAS_BIT_DRIVE]
    ##1 CE && enable_q[NCH-1][LCAS_BIT_DRIVE] |=> CHANGE_IRQ)
    else $error("enabled drive monitor toggle raised no interrupt");

  a_irq_needs_enable: assert property (@(posedge CLK) disable iff (!RESET_N)
    CE && pend == '0 |=> !CHANGE_IRQ)
    else $error("interrupt without an enabled flag");

  c_flags_read: cover property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O && WB_DAT_O != '0 && $past(reg_sel) == LCAS_REG_FLAGS);

  c_enable_write: cover property (@(posedge CLK) disable iff (!RESET_N)
    WB_ACK_O && WB_WE_I && reg_sel == LCAS_REG_ENABLE);

  c_irq_raised: cover property (@(posedge CLK) disable iff (!RESET_N)
    !CHANGE_IRQ ##1 CHANGE_IRQ);

  c_set_during_clear: cover property (@(posedge CLK) disable iff (!RESET_N)
    clr[0] && g_ch[0].u_chan.armed_q &&
    SIGNAL_ABSENT[0] != g_ch[0].u_chan.prev_q[LCAS_BIT_ABSENT]);

endmodule
